// File: bench/pad_far_side.sv
// Far-side model: board drivers sharing each pad wire with the cell
`timescale 1ns/1ps
module pad_far_side #(
	parameter int PINS = 8
) (
	input wire logic [PINS-1:0] pad_o,
	input wire logic [PINS-1:0] pad_oe,
	input wire logic [PINS-1:0] ext_val,
	output logic [PINS-1:0] pad_i
);
	// Board drivers yield wherever the cell drives, so no contention is modelled
	assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext_val);
endmodule

// File: bench/tb.sv
// Self-checking bench for the I/O cell bank
`timescale 1ns/1ps
`include "pad_cell_defs.svh"
module tb;
	import pad_cell_pkg::*;
	logic clock;
	logic rst_n;
	reg_addr_t reg_addr;
	reg_data_t reg_wdata;
	reg_data_t reg_rdata;
	logic reg_wr, reg_rd, in_clk_en, out_clk_en, clock_enable, freeze_hold_control;
	logic pll_ref_in, pll_out, pll_low_power;
	logic [7:0] core_dout, core_oe, core_din, pad_i, pad_o, pad_oe, pad_pullup, ext_val;
	int errors = 0;
	int compares = 0;
	typedef struct {logic [7:0] dout; logic [7:0] oe; logic [7:0] ext; logic [7:0] e_oe; logic [7:0] e_din;} row_t;
	// Pins 0..3 used, so upper pins never drive and read 0
	row_t rows [4] = '{'{8'hA5, 8'h0F, 8'h00, 8'h0F, 8'h05}, '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h0F},
		'{8'hFF, 8'hF0, 8'h00, 8'h00, 8'h00}, '{8'h3C, 8'h0C, 8'hC3, 8'h0C, 8'h0F}};

	programmable_io_cell #(.PINS(8)) i_programmable_io_cell (.clock(clock), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .in_clk_en(in_clk_en), .out_clk_en(out_clk_en),
		.clock_enable(clock_enable), .freeze_hold_control(freeze_hold_control),
		.core_dout(core_dout), .core_oe(core_oe), .core_din(core_din), .pad_i(pad_i),
		.pad_o(pad_o), .pad_oe(pad_oe), .pad_pullup(pad_pullup), .pll_ref_in(pll_ref_in),
		.pll_out(pll_out), .pll_low_power(pll_low_power));
	pad_far_side #(.PINS(8)) i_pad_far_side (.pad_o(pad_o), .pad_oe(pad_oe), .ext_val(ext_val), .pad_i(pad_i));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input reg_addr_t a, input reg_data_t d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input reg_addr_t a, input reg_data_t exp, input string name);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		chk(name, exp, reg_rdata);
	endtask
	// Waits n edges, then samples settled outputs mid-cycle
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask
	task automatic pulse(input logic ce, input logic inp);
		@(posedge clock);
		clock_enable <= ce;
		in_clk_en <= inp;
		out_clk_en <= ~inp;
		@(posedge clock);
		in_clk_en <= 1'b0;
		out_clk_en <= 1'b0;
	endtask
	task automatic print_verdict;
		$display("Counts: %0d compares, %0d errors", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		#200000;
		errors++;
		$display("Watchdog expired");
		print_verdict();
	end

	initial begin
		rst_n = 1'b0;
		{reg_addr, reg_wdata, reg_wr, reg_rd, in_clk_en, out_clk_en, clock_enable} = '0;
		{freeze_hold_control, pll_ref_in, core_dout, ext_val} = '0;
		core_oe = 8'hFF;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		@(negedge clock);
		chk("pad_oe reset", 8'h00, pad_oe);
		chk("pullup reset", 8'hFF, pad_pullup);
		wr(`PAD_OFS_USED, 32'h0F);
		wr(`PAD_OFS_PULLUP, 32'h05);
		wr(`PAD_OFS_CTRL, 32'h01);
		rd(`PAD_OFS_STATUS, 32'h01, "status load");
		chk("pad_oe load", 8'h00, pad_oe);
		wr(`PAD_OFS_CTRL, 32'h02);
		rd(`PAD_OFS_STATUS, 32'h03, "status user");
		rd(`PAD_OFS_USED, 32'h0F, "used readback");
		rd(`PAD_OFS_PULLUP, 32'h05, "pullup readback");
		$display("test config done");
		foreach (rows[i]) begin
			@(posedge clock);
			core_dout <= rows[i].dout;
			core_oe <= rows[i].oe;
			ext_val <= rows[i].ext;
			cyc(4);
			chk("pad_oe", rows[i].e_oe, pad_oe);
			chk("pad_o", rows[i].dout & rows[i].e_oe, pad_o & pad_oe);
			chk("core_din", rows[i].e_din, core_din);
			chk("pad_pullup", 8'h05, pad_pullup);
		end
		$display("test table done");
		wr(`PAD_OFS_OUT_SEL, 32'hFF);
		wr(`PAD_OFS_OE_SEL, 32'hFF);
		@(posedge clock);
		core_dout <= 8'h55;
		core_oe <= 8'hFF;
		pulse(1'b0, 1'b0);
		cyc(1);
		chk("oe reg gated", 8'h00, pad_oe);
		pulse(1'b1, 1'b0);
		@(posedge clock);
		core_dout <= 8'h00;
		cyc(2);
		chk("oe reg", 8'h0F, pad_oe);
		chk("out reg", 8'h05, pad_o & 8'h0F);
		$display("test output regs done");
		wr(`PAD_OFS_OE_SEL, 32'h00);
		wr(`PAD_OFS_IN_SEL, 32'h01);
		@(posedge clock);
		core_oe <= 8'h00;
		ext_val <= 8'hFF;
		cyc(4);
		chk("in reg idle", 8'h0E, core_din);
		pulse(1'b0, 1'b1);
		cyc(1);
		chk("in reg gated", 8'h0E, core_din);
		pulse(1'b1, 1'b1);
		cyc(1);
		chk("in reg load", 8'h0F, core_din);
		wr(`PAD_OFS_FREEZE, 32'h0B);
		@(posedge clock);
		pll_ref_in <= 1'b1;
		cyc(4);
		@(posedge clock);
		freeze_hold_control <= 1'b1;
		ext_val <= 8'h00;
		pll_ref_in <= 1'b0;
		cyc(4);
		chk("frozen din", 8'h0B, core_din);
		chk("pll held", 1'b1, pll_out);
		chk("pll low power", 1'b1, pll_low_power);
		rd(`PAD_OFS_STATUS, 32'h07, "status frozen");
		@(posedge clock);
		freeze_hold_control <= 1'b0;
		cyc(4);
		chk("thawed din", 8'h01, core_din);
		chk("pll thawed", 1'b0, pll_out);
		$display("test freeze done");
		wr(`PAD_OFS_CTRL, 32'h01);
		cyc(1);
		chk("pullup reload", 8'hFF, pad_pullup);
		wr(`PAD_OFS_CTRL, 32'h04);
		rd(`PAD_OFS_STATUS, 32'h00, "status fail");
		rd(8'h20, 32'h00, "unmapped");
		rd(`PAD_OFS_CTRL, 32'h00, "ctrl read");
		@(posedge clock);
		rst_n <= 1'b0;
		cyc(1);
		chk("pad_oe rerst", 8'h00, pad_oe);
		chk("pullup rerst", 8'hFF, pad_pullup);
		@(posedge clock);
		rst_n <= 1'b1;
		rd(`PAD_OFS_STATUS, 32'h00, "status rerst");
		$display("test fail and reset done");
		print_verdict();
	end
endmodule

// File: logic/pad_cell_defs.svh
// Offsets, reset values and field positions of the programmable I/O cell bank
//
// Contract
// - Each cell has input, output and output-enable register stages with selects.
// - Input registers, on the input clock enable, may capture pad values.
// - Output data is registered on the output clock when selected, else passes.
// - Freeze-selected pins hold their unregistered input while freeze is asserted.
// - One freeze control is shared by every cell of the bank.
// - Before configuration every pad is undriven with its weak pull-up on.
// - User settings apply only after reset release and a successful download.
// - Unused cells get their input blocked and pull-up disabled.
// - Each pin selects a weak pull-up or none.
// - Freeze puts the PLL in low power, output held at last level.
`ifndef PAD_CELL_DEFS_SVH
`define PAD_CELL_DEFS_SVH

`define PAD_OFS_USED      8'h00
`define PAD_OFS_IN_SEL    8'h04
`define PAD_OFS_OUT_SEL   8'h08
`define PAD_OFS_OE_SEL    8'h0C
`define PAD_OFS_FREEZE    8'h10
`define PAD_OFS_PULLUP    8'h14
`define PAD_OFS_CTRL      8'h18
`define PAD_OFS_STATUS    8'h1C

`define PAD_RST_CFG       32'h0000_0000
`define PAD_CTRL_START    0
`define PAD_CTRL_DONE     1
`define PAD_CTRL_FAIL     2
`define PAD_STAT_STATE    0
`define PAD_STAT_PLL_LP   2

`endif

// File: logic/pad_cell_pkg.sv
// Types shared by the I/O cell bank
package pad_cell_pkg;
	typedef enum logic [1:0] {
		CFG_DEFAULT = 2'b00,
		CFG_LOAD = 2'b01,
		CFG_USER = 2'b11
	} cfg_state_t;
	typedef logic [7:0] reg_addr_t;
	typedef logic [31:0] reg_data_t;
endpackage

// File: logic/pad_sync.sv
// Two flip-flop synchroniser for a group of pad levels
`timescale 1ns/1ps
module pad_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	initial begin
		if (WIDTH < 1) begin
			$error("pad_sync: WIDTH must be at least 1");
		end
	end

	// First stage feeds only the second stage
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// File: logic/programmable_io_cell.sv
// Bank of programmable I/O cells with configuration registers, freeze and PLL hold
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "pad_cell_defs.svh"
module programmable_io_cell #(
	parameter int PINS = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire pad_cell_pkg::reg_addr_t reg_addr,
	input wire pad_cell_pkg::reg_data_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output pad_cell_pkg::reg_data_t reg_rdata,
	input wire logic in_clk_en,
	input wire logic out_clk_en,
	input wire logic clock_enable,
	input wire logic freeze_hold_control,
	input wire logic [PINS-1:0] core_dout,
	input wire logic [PINS-1:0] core_oe,
	output logic [PINS-1:0] core_din,
	input wire logic [PINS-1:0] pad_i,
	output logic [PINS-1:0] pad_o,
	output logic [PINS-1:0] pad_oe,
	output logic [PINS-1:0] pad_pullup,
	input wire logic pll_ref_in,
	output logic pll_out,
	output logic pll_low_power
);
	import pad_cell_pkg::*;

	initial begin
		if (PINS < 1 || PINS > 32) begin
			$error("programmable_io_cell: PINS must lie in 1..32");
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers

	cfg_state_t state_reg;
	logic [PINS-1:0] used_reg;
	logic [PINS-1:0] in_sel_reg;
	logic [PINS-1:0] out_sel_reg;
	logic [PINS-1:0] oe_sel_reg;
	logic [PINS-1:0] freeze_sel_reg;
	logic [PINS-1:0] pullup_sel_reg;
	logic user_mode;
	logic ctrl_wr;

	assign user_mode = (state_reg == CFG_USER);
	assign ctrl_wr = reg_wr && (reg_addr == `PAD_OFS_CTRL);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			used_reg <= PINS'(`PAD_RST_CFG);
			in_sel_reg <= PINS'(`PAD_RST_CFG);
			out_sel_reg <= PINS'(`PAD_RST_CFG);
			oe_sel_reg <= PINS'(`PAD_RST_CFG);
			freeze_sel_reg <= PINS'(`PAD_RST_CFG);
			pullup_sel_reg <= PINS'(`PAD_RST_CFG);
		end else if (reg_wr) begin
			if (reg_addr == `PAD_OFS_USED) begin
				used_reg <= reg_wdata[PINS-1:0];
			end else if (reg_addr == `PAD_OFS_IN_SEL) begin
				in_sel_reg <= reg_wdata[PINS-1:0];
			end else if (reg_addr == `PAD_OFS_OUT_SEL) begin
				out_sel_reg <= reg_wdata[PINS-1:0];
			end else if (reg_addr == `PAD_OFS_OE_SEL) begin
				oe_sel_reg <= reg_wdata[PINS-1:0];
			end else if (reg_addr == `PAD_OFS_FREEZE) begin
				freeze_sel_reg <= reg_wdata[PINS-1:0];
			end else if (reg_addr == `PAD_OFS_PULLUP) begin
				pullup_sel_reg <= reg_wdata[PINS-1:0];
			end
		end
	end

	// Download sequence: start, then done or fail; a failed load returns to defaults
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= CFG_DEFAULT;
		end else if (ctrl_wr) begin
			case (state_reg)
				CFG_DEFAULT: begin
					if (reg_wdata[`PAD_CTRL_START]) begin
						state_reg <= CFG_LOAD;
					end
				end
				CFG_LOAD: begin
					if (reg_wdata[`PAD_CTRL_FAIL]) begin
						state_reg <= CFG_DEFAULT;
					end else if (reg_wdata[`PAD_CTRL_DONE]) begin
						state_reg <= CFG_USER;
					end
				end
				CFG_USER: begin
					if (reg_wdata[`PAD_CTRL_START]) begin
						state_reg <= CFG_LOAD;
					end
				end
				default: begin
					state_reg <= CFG_DEFAULT;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register read port, data one cycle after the strobe

	logic [PINS-1:0] sync_pad;
	logic pll_ref_sync;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			if (reg_addr == `PAD_OFS_USED) begin
				reg_rdata <= 32'(used_reg);
			end else if (reg_addr == `PAD_OFS_IN_SEL) begin
				reg_rdata <= 32'(in_sel_reg);
			end else if (reg_addr == `PAD_OFS_OUT_SEL) begin
				reg_rdata <= 32'(out_sel_reg);
			end else if (reg_addr == `PAD_OFS_OE_SEL) begin
				reg_rdata <= 32'(oe_sel_reg);
			end else if (reg_addr == `PAD_OFS_FREEZE) begin
				reg_rdata <= 32'(freeze_sel_reg);
			end else if (reg_addr == `PAD_OFS_PULLUP) begin
				reg_rdata <= 32'(pullup_sel_reg);
			end else if (reg_addr == `PAD_OFS_STATUS) begin
				reg_rdata <= {29'h0, pll_low_power, state_reg};
			end else begin
				reg_rdata <= 32'h0000_0000;
			end
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pad and reference inputs cross into the clock domain

	pad_sync #(.WIDTH(PINS)) u_pad_sync (
		.clock(clock),
		.rst_n(rst_n),
		.async_in(pad_i),
		.sync_out(sync_pad)
	);

	pad_sync #(.WIDTH(1)) u_pll_sync (
		.clock(clock),
		.rst_n(rst_n),
		.async_in(pll_ref_in),
		.sync_out(pll_ref_sync)
	);

	////////////////////////////////////////////////////////////////////////////
	// Per-pin stages

	logic [PINS-1:0] in_reg;
	logic [PINS-1:0] pass_reg;
	logic [PINS-1:0] out_reg;
	logic [PINS-1:0] oe_reg;
	logic [PINS-1:0] active;
	logic [PINS-1:0] frozen;

	generate
		for (genvar i = 0; i < PINS; i++) begin : g_pin
			// Cells not used by the loaded configuration see no pad activity
			assign active[i] = user_mode && used_reg[i];
			// One bank-wide control, gated per pin by its freeze select
			assign frozen[i] = freeze_hold_control && freeze_sel_reg[i];

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					in_reg[i] <= 1'b0;
				end else if (in_clk_en && clock_enable) begin
					in_reg[i] <= active[i] ? sync_pad[i] : 1'b0;
				end
			end

			// Unregistered path still needs a flop to act as the freeze latch
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					pass_reg[i] <= 1'b0;
				end else if (!frozen[i]) begin
					pass_reg[i] <= active[i] ? sync_pad[i] : 1'b0;
				end
			end

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					out_reg[i] <= 1'b0;
					oe_reg[i] <= 1'b0;
				end else if (out_clk_en && clock_enable) begin
					out_reg[i] <= core_dout[i];
					oe_reg[i] <= core_oe[i];
				end
			end

			// Registered inputs ignore freeze; the core drops clock_enable instead
			assign core_din[i] = in_sel_reg[i] ? in_reg[i] : pass_reg[i];
			assign pad_o[i] = out_sel_reg[i] ? out_reg[i] : core_dout[i];
			assign pad_oe[i] = active[i] && (oe_sel_reg[i] ? oe_reg[i] : core_oe[i]);
			assign pad_pullup[i] = user_mode ? (used_reg[i] && pullup_sel_reg[i]) : 1'b1;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// PLL hold

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pll_out <= 1'b0;
		end else if (!freeze_hold_control) begin
			pll_out <= pll_ref_sync;
		end
	end

	assign pll_low_power = freeze_hold_control;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_load_start;
		state_reg == CFG_DEFAULT && ctrl_wr && reg_wdata[`PAD_CTRL_START];
	endsequence

	sequence s_load_ok;
		state_reg == CFG_LOAD && ctrl_wr && reg_wdata[`PAD_CTRL_DONE] && !reg_wdata[`PAD_CTRL_FAIL];
	endsequence

	default_pads_a: assert property (@(posedge clock) disable iff (!rst_n)
		!user_mode |-> (pad_oe == '0 && pad_pullup == '1))
		else $error("pad driven or pull-up off before configuration");

	user_after_load_a: assert property (@(posedge clock) disable iff (!rst_n)
		s_load_start ##[1:20] s_load_ok |=> user_mode)
		else $error("successful download did not enter user mode");

	no_user_early_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(user_mode) |-> $past(state_reg) == CFG_LOAD && $past(ctrl_wr))
		else $error("user mode entered without a completed download");

	unused_blocked_a: assert property (@(posedge clock) disable iff (!rst_n)
		user_mode |-> ((pass_reg & ~$past(used_reg) & ~$past(frozen)) == '0 && (pad_pullup & ~used_reg) == '0))
		else $error("unused cell passes input or keeps pull-up");

	freeze_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		(frozen[0] && $past(frozen[0])) |-> $stable(pass_reg[0]))
		else $error("frozen input changed");

	ce_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		$past(!clock_enable) |-> ($stable(in_reg) && $stable(out_reg) && $stable(oe_reg)))
		else $error("stage register changed without clock enable");

	out_reg_path_a: assert property (@(posedge clock) disable iff (!rst_n)
		(out_clk_en && clock_enable && out_sel_reg[0]) ##1 $stable(out_sel_reg[0])
			|-> pad_o[0] == $past(core_dout[0]))
		else $error("registered output does not follow core data");

	pad_drive_a: assert property (@(posedge clock) disable iff (!rst_n)
		pad_oe[0] |-> (active[0] && (oe_sel_reg[0] ? oe_reg[0] : core_oe[0])))
		else $error("pad driven without output enable");

	pll_static_a: assert property (@(posedge clock) disable iff (!rst_n)
		freeze_hold_control [*3] |-> (pll_low_power && $stable(pll_out)))
		else $error("PLL output moved while held");

	input_reg_a: assert property (@(posedge clock) disable iff (!rst_n)
		(in_clk_en && clock_enable && active[0]) |=> in_reg[0] == $past(sync_pad[0]))
		else $error("input register missed pad value");

	////////////////////////////////////////////////////////////////////////////
	// Bus, configuration and per-stage checks

	sequence s_ctrl_start;
		ctrl_wr && reg_wdata[`PAD_CTRL_START];
	endsequence

	rdata_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
		!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data not zero outside the read answer cycle");

	status_read_a: assert property (@(posedge clock) disable iff (!rst_n)
		($past(reg_rd) && $past(reg_addr) == `PAD_OFS_STATUS)
			|-> (reg_rdata[1:0] == $past(state_reg) && reg_rdata[2] == $past(pll_low_power)))
		else $error("status read does not show state and PLL power");

	ctrl_read_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
		($past(reg_rd) && $past(reg_addr) == `PAD_OFS_CTRL) |-> reg_rdata == '0)
		else $error("control register read is not zero");

	used_readback_a: assert property (@(posedge clock) disable iff (!rst_n)
		($past(reg_rd) && $past(reg_addr) == `PAD_OFS_USED) |-> reg_rdata == 32'($past(used_reg)))
		else $error("used-pin register read back wrong");

	fail_to_default_a: assert property (@(posedge clock) disable iff (!rst_n)
		(state_reg == CFG_LOAD && ctrl_wr && reg_wdata[`PAD_CTRL_FAIL]) |=> state_reg == CFG_DEFAULT)
		else $error("failed download did not return to defaults");

	restart_load_a: assert property (@(posedge clock) disable iff (!rst_n)
		user_mode ##0 s_ctrl_start |=> (pad_oe == '0 && pad_pullup == '1))
		else $error("new download left pads in user state");

	load_from_start_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(state_reg == CFG_LOAD) |-> $past(ctrl_wr && reg_wdata[`PAD_CTRL_START]))
		else $error("download entered without a start command");

	pullup_user_a: assert property (@(posedge clock) disable iff (!rst_n)
		user_mode |-> pad_pullup == (used_reg & pullup_sel_reg))
		else $error("pull-up does not follow its per-pin select");

	no_drive_unused_a: assert property (@(posedge clock) disable iff (!rst_n)
		(pad_oe & ~used_reg) == '0)
		else $error("unused pin is driven");

	thaw_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
		(!frozen[0] && active[0]) |=> pass_reg[0] == $past(sync_pad[0]))
		else $error("unfrozen input did not follow the pad");

	bank_freeze_a: assert property (@(posedge clock) disable iff (!rst_n)
		$past(freeze_hold_control) |-> ((pass_reg ^ $past(pass_reg)) & $past(freeze_sel_reg)) == '0)
		else $error("a freeze-selected input of the bank changed");

	oe_reg_load_a: assert property (@(posedge clock) disable iff (!rst_n)
		(out_clk_en && clock_enable) |=> (oe_reg == $past(core_oe) && out_reg == $past(core_dout)))
		else $error("output stage registers missed core values");

	in_reg_gated_a: assert property (@(posedge clock) disable iff (!rst_n)
		!(in_clk_en && clock_enable) |=> $stable(in_reg))
		else $error("input register changed without its enables");

	out_reg_gated_a: assert property (@(posedge clock) disable iff (!rst_n)
		!(out_clk_en && clock_enable) |=> ($stable(out_reg) && $stable(oe_reg)))
		else $error("output stage changed without its enables");

	pll_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
		!freeze_hold_control |=> pll_out == $past(pll_ref_sync))
		else $error("PLL output does not follow its reference");

	pad_out_path_a: assert property (@(posedge clock) disable iff (!rst_n)
		!out_sel_reg[0] |-> pad_o[0] == core_dout[0])
		else $error("unregistered output does not pass core data");
endmodule
